// File: common/seq_pkg.sv
// shared constants and types for the interrupt and stack sequencer
package seq_pkg;
	localparam int          ADDR_W         = 16;
	localparam int          USED_ADDR_W    = 10;
	localparam int          SP_W           = 5;
	localparam logic [10:0] STACK_PAGE     = 11'h007;
	localparam logic [4:0]  SP_RESET       = 5'h1F;
	localparam logic [9:0]  VEC_TIMER      = 10'h3F8;
	localparam logic [9:0]  VEC_EXT        = 10'h3FA;
	localparam logic [9:0]  VEC_TRAP       = 10'h3FC;
	localparam logic [9:0]  VEC_RESET      = 10'h3FE;
	localparam int          MASK_BIT       = 3;
	localparam logic [7:0]  CCR_RESET      = 8'hE8;
	localparam logic [2:0]  FRAME_LAST     = 3'h4;
	typedef enum logic [1:0] {SRC_NONE, SRC_TIMER, SRC_EXT, SRC_TRAP} src_t;
endpackage : seq_pkg

// File: common/mem_if.sv
// memory request carrier between sequencer and its address former
`timescale 1ns/10ps
interface mem_if;
	logic        use_stack;
	logic [4:0]  sp;
	logic [15:0] raw_addr;
	logic [15:0] addr;
	modport seq  (output use_stack, output sp, output raw_addr, input addr);
	modport form (input use_stack, input sp, input raw_addr, output addr);
endinterface : mem_if

// File: hdl/addr_former.sv
// forms physical memory addresses from stack pointer or raw address
`timescale 1ns/10ps
module addr_former
	import seq_pkg::*;
(
	mem_if.form m
);
	always_comb begin
		if (m.use_stack) begin
			m.addr = {STACK_PAGE, m.sp};
		end else begin
			m.addr = {6'h00, m.raw_addr[USED_ADDR_W-1:0]};
		end
	end
endmodule : addr_former

// File: hdl/cpu_interrupt_stack_sequencer.sv
// interrupt entry, return, reset vectoring and stack sequencing for the core
`timescale 1ns/10ps
// Operation
// - only the low ten address bits are decoded; upper six ignored
// - five-bit stack pointer wraps from 00E0 to 00FF
// - stack address is 00000000111 above the five pointer bits
// - pointer names next free slot: write then decrement
// - pushed program counter has its top six bits zero
// - an option bit can change what the stop instruction does
// - option set runs stop as halt; clear gives normal stop
// - taking an interrupt stacks registers and sets the mask flag
// - hardware requests wait for instruction end; reset acts at once
// - hardware requests enter service only if mask clear and source enabled
// - finish, push, set mask, then sample requests
// - highest vector address wins among pending hardware requests
// - vectors at 03F8..03FF fetched high byte first
// - software trap is taken whatever the mask flag
// - pending hardware requests are served before a fetched trap
// - return pops registers and resumes the interrupted instruction
// - reset loads counter from 03FE/03FF and sets the mask flag
// - mask flag blocks all hardware requests except reset
// - four causes: trap, external line, port pins, timer
// - external pending raises a request only while enabled
// - entering external service clears the external latch
module cpu_interrupt_stack_sequencer
	import seq_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        internal_reset_signal,
	input  wire logic        instr_boundary,
	input  wire logic        trap_fetched,
	input  wire logic        return_fetched,
	input  wire logic        stop_fetched,
	input  wire logic        stop_as_halt_opt,
	input  wire logic        port_irq_opt,
	input  wire logic        external_request_pending,
	input  wire logic        external_request_enable,
	input  wire logic        port_a_low_nibble_pins_req,
	input  wire logic        counter_overflow_flag,
	input  wire logic        periodic_tick_flag,
	input  wire logic        timer_overflow_enable,
	input  wire logic        timer_tick_enable,
	input  wire logic [15:0] pc_in,
	input  wire logic [7:0]  acc_in,
	input  wire logic [7:0]  idx_in,
	input  wire logic [7:0]  ccr_in,
	input  wire logic        ccr_load,
	input  wire logic [7:0]  mem_rdata,
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	output logic             mem_we,
	output logic             mem_re,
	output logic      [15:0] program_counter,
	output logic      [7:0]  accumulator,
	output logic      [7:0]  index_reg,
	output logic      [7:0]  condition_code_register,
	output logic      [4:0]  stack_pointer,
	output logic             core_busy,
	output logic             resume_strobe,
	output logic             enter_stop,
	output logic             enter_halt,
	output logic             clear_external_latch
);
	typedef enum logic [2:0] {ST_RUN, ST_PUSH, ST_SEL, ST_VECH, ST_VECL, ST_POP} state_t;

	logic        rst_pin_m, rst_pin_s1, rst_pin_s2;
	logic        ext_req, timer_req, hw_req;
	state_t      state_q, state_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [4:0]  sp_q, sp_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0]  a_q, a_d, x_q, x_d, ccr_q, ccr_d;
	logic [9:0]  vec_q, vec_d;
	logic        from_reset_q, from_reset_d;
	logic        trap_q, trap_d;
	logic        busy_d, resume_d, stop_d, halt_d, clr_d;
	logic        busy_q, resume_q, stop_q, halt_q, clr_q;
	logic        mask;
	mem_if       m ();

	// internal reset is same-clock logic; sample through three flops anyway for glitch safety
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rst_pin_m  <= 1'b1;
			rst_pin_s1 <= 1'b1;
			rst_pin_s2 <= 1'b1;
		end else begin
			rst_pin_m  <= internal_reset_signal;
			rst_pin_s1 <= rst_pin_m;
			rst_pin_s2 <= rst_pin_s1;
		end
	end

	function automatic logic [7:0] frame_byte(input logic [2:0] i, input logic [15:0] pc,
			input logic [7:0] x, input logic [7:0] a, input logic [7:0] c);
		case (i)
			3'h0:    frame_byte = pc[7:0];
			3'h1:    frame_byte = {6'h00, pc[9:8]};
			3'h2:    frame_byte = x;
			3'h3:    frame_byte = a;
			default: frame_byte = c;
		endcase
	endfunction : frame_byte

	assign mask      = ccr_q[MASK_BIT];
	assign ext_req   = (external_request_pending
		| (port_irq_opt & port_a_low_nibble_pins_req)) & external_request_enable;
	assign timer_req = (counter_overflow_flag & timer_overflow_enable)
		| (periodic_tick_flag & timer_tick_enable);
	assign hw_req    = (ext_req | timer_req) & ~mask;

	assign m.sp = sp_q;

	addr_former u_addr (
		.m (m)
	);

	always_comb begin
		state_d      = state_q;
		cnt_d        = cnt_q;
		sp_d         = sp_q;
		pc_d         = pc_q;
		a_d          = a_q;
		x_d          = x_q;
		ccr_d        = ccr_q;
		vec_d        = vec_q;
		from_reset_d = from_reset_q;
		trap_d       = trap_q;
		busy_d       = 1'b1;
		resume_d     = 1'b0;
		stop_d       = 1'b0;
		halt_d       = 1'b0;
		clr_d        = 1'b0;
		m.use_stack  = 1'b0;
		m.raw_addr   = pc_q;
		mem_we       = 1'b0;
		mem_re       = 1'b0;
		mem_wdata    = 8'h00;
		case (state_q)
			ST_RUN: begin
				busy_d = 1'b0;
				if (ccr_load) begin
					ccr_d = ccr_in;
				end
				if (instr_boundary) begin
					pc_d = pc_in;
					a_d  = acc_in;
					x_d  = idx_in;
					if (hw_req | trap_fetched) begin
						trap_d  = trap_fetched & ~hw_req;
						cnt_d   = 3'h0;
						state_d = ST_PUSH;
						busy_d  = 1'b1;
					end else if (return_fetched) begin
						cnt_d   = FRAME_LAST;
						state_d = ST_POP;
						busy_d  = 1'b1;
					end else if (stop_fetched) begin
						stop_d = ~stop_as_halt_opt;
						halt_d = stop_as_halt_opt;
					end
				end
			end
			ST_PUSH: begin
				m.use_stack = 1'b1;
				mem_we      = 1'b1;
				mem_wdata   = frame_byte(cnt_q, pc_q, x_q, a_q, ccr_q);
				sp_d        = sp_q - 5'h01;
				cnt_d       = cnt_q + 3'h1;
				if (cnt_q == FRAME_LAST) begin
					ccr_d[MASK_BIT] = 1'b1;
					state_d         = ST_SEL;
				end
			end
			ST_SEL: begin
				// sample requests only after stacking and masking
				if (trap_q) begin
					vec_d = VEC_TRAP;
				end else if (ext_req) begin
					vec_d = VEC_EXT;
					clr_d = 1'b1;
				end else begin
					vec_d = VEC_TIMER;
				end
				state_d = ST_VECH;
			end
			ST_VECH: begin
				m.raw_addr  = {6'h00, vec_q};
				mem_re      = 1'b1;
				pc_d[15:8]  = {6'h00, mem_rdata[1:0]};
				state_d     = ST_VECL;
			end
			ST_VECL: begin
				m.raw_addr   = {6'h00, vec_q} + 16'h0001;
				mem_re       = 1'b1;
				pc_d[7:0]    = mem_rdata;
				from_reset_d = 1'b0;
				resume_d     = 1'b1;
				state_d      = ST_RUN;
			end
			ST_POP: begin
				m.use_stack = 1'b1;
				m.raw_addr  = pc_q;
				mem_re      = 1'b1;
				// read the slot one above the pointer before incrementing
				m.use_stack = 1'b1;
				sp_d        = sp_q + 5'h01;
				cnt_d       = cnt_q - 3'h1;
				case (cnt_q)
					3'h4:    ccr_d = mem_rdata;
					3'h3:    a_d = mem_rdata;
					3'h2:    x_d = mem_rdata;
					3'h1:    pc_d[15:8] = {6'h00, mem_rdata[1:0]};
					default: pc_d[7:0] = mem_rdata;
				endcase
				if (cnt_q == 3'h0) begin
					resume_d = 1'b1;
					state_d  = ST_RUN;
				end
			end
			default: state_d = ST_RUN;
		endcase
		if (rst_pin_s2 & rst_pin_s1) begin
			state_d      = ST_VECH;
			vec_d        = VEC_RESET;
			sp_d         = SP_RESET;
			ccr_d        = CCR_RESET;
			from_reset_d = 1'b1;
		end
	end

	// pop reads one above the pointer: override the stack slot during pop
	logic [4:0] pop_sp;
	assign pop_sp = sp_q + 5'h01;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q      <= ST_VECH;
			cnt_q        <= 3'h0;
			sp_q         <= SP_RESET;
			pc_q         <= 16'h0000;
			a_q          <= 8'h00;
			x_q          <= 8'h00;
			ccr_q        <= CCR_RESET;
			vec_q        <= VEC_RESET;
			from_reset_q <= 1'b1;
			trap_q       <= 1'b0;
			busy_q       <= 1'b1;
			resume_q     <= 1'b0;
			stop_q       <= 1'b0;
			halt_q       <= 1'b0;
			clr_q        <= 1'b0;
		end else begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			sp_q         <= sp_d;
			pc_q         <= pc_d;
			a_q          <= a_d;
			x_q          <= x_d;
			ccr_q        <= ccr_d;
			vec_q        <= vec_d;
			from_reset_q <= from_reset_d;
			trap_q       <= trap_d;
			busy_q       <= busy_d;
			resume_q     <= resume_d;
			stop_q       <= stop_d;
			halt_q       <= halt_d;
			clr_q        <= clr_d;
		end
	end

	assign mem_addr = (state_q == ST_POP) ? {STACK_PAGE, pop_sp} : m.addr;
	assign program_counter         = pc_q;
	assign accumulator             = a_q;
	assign index_reg               = x_q;
	assign condition_code_register = ccr_q;
	assign stack_pointer           = sp_q;
	assign core_busy               = busy_q;
	assign resume_strobe           = resume_q;
	assign enter_stop              = stop_q;
	assign enter_halt              = halt_q;
	assign clear_external_latch    = clr_q;

	// stack wraps after 32 pushes
	sp_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_PUSH && sp_q == 5'h00) |=> sp_q == 5'h1F)
		else $error("stack pointer did not wrap to top");
	// pushed counter high byte has zero upper bits
	pc_high_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_PUSH && cnt_q == 3'h1) |-> mem_wdata[7:2] == 6'h00)
		else $error("pushed counter high byte not cleared");
	// mask set at end of stacking
	mask_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_PUSH && cnt_q == FRAME_LAST) |=> ccr_q[MASK_BIT])
		else $error("mask not set after stacking");
	// stack writes use the stack page
	stack_page_a: assert property (@(posedge ref_clk) disable iff (rst)
		mem_we |-> mem_addr[15:5] == STACK_PAGE)
		else $error("stack write outside stack page");
	// five writes then select
	push_len_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_RUN && state_d == ST_PUSH) |=> mem_we [*5] ##1 state_q == ST_SEL)
		else $error("push frame length wrong");
	// masked hardware requests do not start entry
	mask_blocks_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_RUN && mask && !trap_fetched && !rst_pin_s2) |=> state_q != ST_PUSH)
		else $error("entry taken while masked");
	// trap always taken at boundary
	trap_taken_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_RUN && instr_boundary && trap_fetched && !rst_pin_s2)
		|=> state_q == ST_PUSH)
		else $error("trap not taken");
	// halt option steers stop
	stop_halt_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_RUN && instr_boundary && stop_fetched && !trap_fetched && !hw_req
		&& !return_fetched && !rst_pin_s2) |=> enter_halt == $past(stop_as_halt_opt))
		else $error("stop conversion wrong");
	// external entry clears latch
	ext_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_SEL && !trap_q && ext_req && !rst_pin_s2) |=> clear_external_latch)
		else $error("external latch not cleared");
	// reset fetch starts at the reset vector
	reset_vec_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == ST_VECH && from_reset_q) |-> mem_addr == {6'h00, VEC_RESET})
		else $error("reset fetch not at reset vector");
	// reads never drive the ignored upper address bits
	addr_top_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		mem_re |-> mem_addr[15:10] == 6'h00)
		else $error("upper address bits not cleared");
endmodule : cpu_interrupt_stack_sequencer

// File: tb/mem_model.sv
// behavioural memory holding the vector table and the stack ram
`timescale 1ns/10ps
module mem_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_we,
	input  wire logic        mem_re,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [0:1023];
	logic [7:0] noise_q = 8'h5A;
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 8'(i * 7);
		end
	end
	always @(posedge ref_clk) begin
		noise_q <= ~noise_q + 8'h13;
		if (mem_we) begin
			mem[mem_addr[9:0]] <= mem_wdata;
		end
	end
	// unread cycles give a moving pattern, never a stale byte
	assign mem_rdata = mem_re ? mem[mem_addr[9:0]] : noise_q;
endmodule : mem_model

// File: tb/cpu_interrupt_stack_sequencer_tb_top.sv
// self-checking bench for the interrupt and stack sequencer
`timescale 1ns/10ps
module cpu_interrupt_stack_sequencer_tb_top;
	import seq_pkg::*;
	logic        ref_clk = 1'b0, rst = 1'b1, internal_reset_signal, instr_boundary;
	logic        trap_fetched, return_fetched, stop_fetched, stop_as_halt_opt, port_irq_opt;
	logic        external_request_pending, external_request_enable, port_a_low_nibble_pins_req;
	logic        counter_overflow_flag, periodic_tick_flag, timer_overflow_enable;
	logic        timer_tick_enable, ccr_load, mem_we, mem_re, core_busy, resume_strobe;
	logic        enter_stop, enter_halt, clear_external_latch;
	logic [15:0] pc_in, mem_addr, program_counter;
	logic [7:0]  acc_in, idx_in, ccr_in, mem_rdata, mem_wdata, accumulator, index_reg;
	logic [7:0]  condition_code_register, exp_ccr;
	logic [4:0]  stack_pointer, exp_sp;
	logic [23:0] wq[$], pq[$], vq[$];
	logic [33:0] fr[$];
	int          n_errors = 0, tests_run = 0;
	always #25 ref_clk = ~ref_clk;
	cpu_interrupt_stack_sequencer dut_u (.ref_clk, .rst, .internal_reset_signal,
		.instr_boundary, .trap_fetched, .return_fetched, .stop_fetched, .stop_as_halt_opt,
		.port_irq_opt, .external_request_pending, .external_request_enable,
		.port_a_low_nibble_pins_req, .counter_overflow_flag, .periodic_tick_flag,
		.timer_overflow_enable, .timer_tick_enable, .pc_in, .acc_in, .idx_in, .ccr_in,
		.ccr_load, .mem_rdata, .mem_addr, .mem_wdata, .mem_we, .mem_re, .program_counter,
		.accumulator, .index_reg, .condition_code_register, .stack_pointer, .core_busy,
		.resume_strobe, .enter_stop, .enter_halt, .clear_external_latch);
	mem_model mem_u (.ref_clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
	function automatic logic [23:0] vec(input logic [9:0] a);
		return {14'h0, 2'(a * 7), 8'((a + 1) * 7)};
	endfunction : vec
	task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic wait_resume();
		int i;
		i = 0;
		while (resume_strobe !== 1'b1 && i < 40) begin
			@(negedge ref_clk);
			i++;
		end
		if (i == 40) check("resume wait", 24'h1, 24'h0);
	endtask : wait_resume
	task automatic bnd(input logic [2:0] trs);
		@(posedge ref_clk);
		{trap_fetched, return_fetched, stop_fetched} <= trs;
		instr_boundary <= 1'b1;
		@(posedge ref_clk);
		{trap_fetched, return_fetched, stop_fetched} <= 3'b000;
		instr_boundary <= 1'b0;
	endtask : bnd
	task automatic enter(input logic [2:0] trs, input logic [9:0] v, input logic [2:0] pls);
		logic [15:0] p;
		logic [7:0]  a, x;
		logic [7:0]  b [5];
		p = 16'($urandom);
		a = 8'($urandom);
		x = 8'($urandom);
		pc_in <= p;
		acc_in <= a;
		idx_in <= x;
		fr.push_back({p[9:0], a, x, exp_ccr});
		b = '{p[7:0], {6'h0, p[9:8]}, x, a, exp_ccr};
		for (int i = 0; i < 5; i++) begin
			wq.push_back({11'h007, exp_sp, b[i]});
			exp_sp = exp_sp - 5'd1;
		end
		exp_ccr[MASK_BIT] = 1'b1;
		pq.push_back(vec(v));
		if (pls != 3'b000) vq.push_back(24'(pls));
		bnd(trs);
		wait_resume();
		check("mask after entry", 24'(exp_ccr), 24'(condition_code_register));
		@(posedge ref_clk);
	endtask : enter
	task automatic leave();
		logic [33:0] f;
		f = fr.pop_back();
		pq.push_back({14'h0, f[33:24]});
		exp_sp = exp_sp + 5'd5;
		exp_ccr = f[7:0];
		bnd(3'b010);
		wait_resume();
		check("restored", f[23:0], {accumulator, index_reg, condition_code_register});
		@(posedge ref_clk);
	endtask : leave
	task automatic none(input logic [2:0] trs);
		bnd(trs);
		repeat (12) @(negedge ref_clk);
		check("sp idle", 24'(exp_sp), 24'(stack_pointer));
		check("busy idle", 24'h0, 24'(core_busy));
		@(posedge ref_clk);
	endtask : none
	always @(negedge ref_clk) begin
		if (!rst && mem_we === 1'b1) begin
			check("stack write", wq.size() ? wq.pop_front() : ~{mem_addr, mem_wdata},
				{mem_addr, mem_wdata});
		end
		if (!rst && resume_strobe === 1'b1) begin
			check("resume pc", pq.size() ? pq.pop_front() : ~24'(program_counter),
				24'(program_counter));
		end
		if (!rst && (enter_stop | enter_halt | clear_external_latch) !== 1'b0) begin
			check("pulse", vq.size() ? vq.pop_front() : 24'h0,
				{21'h0, enter_stop, enter_halt, clear_external_latch});
		end
	end
	initial begin
		#2000000;
		check("watchdog", 24'h1, 24'h0);
		final_report();
	end
	initial begin
		{internal_reset_signal, instr_boundary, trap_fetched, return_fetched} = '0;
		{stop_fetched, stop_as_halt_opt, port_irq_opt, external_request_pending} = '0;
		{external_request_enable, port_a_low_nibble_pins_req, counter_overflow_flag} = '0;
		{periodic_tick_flag, timer_overflow_enable, timer_tick_enable, ccr_load} = '0;
		{pc_in, acc_in, idx_in, ccr_in} = '0;
		void'($urandom(32'hd6fe));
		exp_sp = SP_RESET;
		exp_ccr = CCR_RESET;
		pq.push_back(vec(VEC_RESET));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		wait_resume();
		check("reset state", {11'h0, exp_sp, exp_ccr}, {11'h0, stack_pointer, condition_code_register});
		@(posedge ref_clk);
		$display("test reset done");
		{counter_overflow_flag, timer_overflow_enable} <= 2'b11;
		none(3'b000);
		ccr_load <= 1'b1;
		@(posedge ref_clk);
		ccr_load <= 1'b0;
		exp_ccr = 8'h00;
		repeat (6) @(posedge ref_clk);
		enter(3'b000, VEC_TIMER, 3'b000);
		counter_overflow_flag <= 1'b0;
		leave();
		$display("test timer done");
		{external_request_pending, external_request_enable} <= 2'b11;
		{periodic_tick_flag, timer_tick_enable} <= 2'b11;
		enter(3'b100, VEC_EXT, 3'b001);
		enter(3'b100, VEC_TRAP, 3'b000);
		leave();
		leave();
		$display("test priority done");
		{external_request_enable, periodic_tick_flag} <= 2'b00;
		none(3'b000);
		{port_irq_opt, port_a_low_nibble_pins_req, external_request_pending} <= 3'b110;
		external_request_enable <= 1'b1;
		enter(3'b000, VEC_EXT, 3'b001);
		$display("test port done");
		vq.push_back(24'h4);
		bnd(3'b001);
		repeat (4) @(posedge ref_clk);
		stop_as_halt_opt <= 1'b1;
		vq.push_back(24'h2);
		bnd(3'b001);
		repeat (4) @(posedge ref_clk);
		$display("test stop done");
		repeat (7) enter(3'b100, VEC_TRAP, 3'b000);
		@(negedge ref_clk);
		check("sp wrap", 24'(exp_sp), 24'(stack_pointer));
		@(posedge ref_clk);
		$display("test wrap done");
		exp_sp = SP_RESET;
		exp_ccr = CCR_RESET;
		pq.push_back(vec(VEC_RESET));
		internal_reset_signal <= 1'b1;
		repeat (5) @(posedge ref_clk);
		internal_reset_signal <= 1'b0;
		wait_resume();
		check("reset state", {11'h0, exp_sp, exp_ccr}, {11'h0, stack_pointer, condition_code_register});
		$display("test internal reset done");
		final_report();
	end
endmodule : cpu_interrupt_stack_sequencer_tb_top
